/* verilog/nvd_bank.sv */
`timescale 1ns/100ps
`default_nettype none
`include "nvd_map.svh"
module nvd_bank
    import nvd_pkg::*;
#(
    parameter int unsigned     WR_CYCLES     = `NVD_WR_CYCLES,
    parameter longint unsigned REBOOT_CYCLES = `NVD_REBOOT_CYC
)(
    input  wire logic      ref_clk,              // 10 MHz clock
    input  wire logic      srst,                 // sync reset, high
    input  wire logic      cmd_valid,            // register command
    input  wire logic      cmd_write,            // 1 write, 0 read
    input  wire nvd_byte_t cmd_addr,             // command byte address
    input  wire nvd_byte_t cmd_wdata,            // write data
    output var  logic      rsp_valid,            // answer pulse
    output var  nvd_byte_t rsp_rdata,            // read data
    output var  logic      rsp_hit,              // accepted in bank
    input  wire logic      log_enable,           // logging enable bit
    input  wire logic      fault_rise,           // new fault pulse
    input  wire nvd_byte_t fault_log_in,         // volatile fault log
    input  wire logic      adc_alert_new,        // new adc alert pulse
    input  wire nvd_byte_t adc_log_in,           // volatile adc log
    input  wire logic      fault_mask_default,   // stored mask bit
    input  wire logic      reboot_req,           // reboot pulse
    output var  logic      nv_busy,              // write in progress
    output var  logic      power_off,            // device held off
    output var  logic      boot_done,            // restart pulse
    output var  logic      restore_valid,        // fault log restore
    output var  nvd_byte_t restore_fault_log,    // restored value
    output var  nvd_byte_t cfg_alert_lo,         // alert mask byte 1
    output var  nvd_byte_t cfg_alert_hi,         // alert mask byte 2
    output var  nvd_byte_t cfg_fet_timeout,      // fet timeout
    output var  nvd_byte_t cfg_io_setup,         // io setup
    output var  nvd_byte_t cfg_aux_low_limit,    // aux low limit
    output var  nvd_byte_t cfg_aux_high_limit,   // aux high limit
    output var  nvd_byte_t cfg_source_low_limit, // source low limit
    output var  nvd_byte_t cfg_source_high_limit,// source high limit
    output var  nvd_byte_t cfg_sense_low_limit,  // sense low limit
    output var  nvd_byte_t cfg_sense_high_limit, // sense high limit
    output var  nvd_byte_t cfg_watt_low_limit,   // watt low limit
    output var  nvd_byte_t cfg_watt_high_limit,  // watt high limit
    output var  nvd_byte_t cfg_timebase          // timebase divider
);

// ==========================================
// bank storage

    localparam int unsigned NV_N = `NVD_NV_COUNT;

    // shipped contents, bank order
    // defaults of all fifteen bytes
    localparam nvd_byte_t SHIP [0:NV_N-1] = '{
        `NVD_ALERT_LO_DEF, `NVD_ALERT_HI_DEF,
        `NVD_FAULT_LOG_DEF, `NVD_ADC_LOG_DEF,
        `NVD_FET_DEF, `NVD_IO_DEF,
        `NVD_AUX_LO_DEF, `NVD_AUX_HI_DEF,
        `NVD_SRC_LO_DEF, `NVD_SRC_HI_DEF,
        `NVD_SNS_LO_DEF, `NVD_SNS_HI_DEF,
        `NVD_WATT_LO_DEF, `NVD_WATT_HI_DEF,
        `NVD_TIMEBASE_DEF};

    // bank index of a byte address
    function automatic nvd_idx_t idx_of(input nvd_byte_t ofs);
        nvd_byte_t d;
        d = ofs - `NVD_NV_FIRST;
        return d[3:0];
    endfunction : idx_of

    localparam nvd_idx_t IDX_FAULT = idx_of(`NVD_FAULT_LOG_OFS);
    localparam nvd_idx_t IDX_ADC   = idx_of(`NVD_ADC_LOG_OFS);

    nvd_byte_t  nv_mem_r [0:NV_N-1];
    logic       busy_r;
    logic [15:0] wr_cnt_r;
    nvd_idx_t   wr_idx_r;
    nvd_byte_t  wr_data_r;
    logic       fault_pend_r;
    nvd_byte_t  fault_data_r;
    logic       adc_pend_r;
    nvd_byte_t  adc_data_r;
    nvd_state_t state_r;
    logic [31:0] dly_cnt_r;
    logic       cmd_hit;
    nvd_idx_t   cmd_idx;
    nvd_byte_t  rd_peek;
    logic       host_wr;
    logic       st_fault;
    logic       st_adc;
    logic       commit;
    logic       load_cfg;

// ==========================================
// command decode

    // address window and start arbitration
    assign cmd_hit  = (cmd_addr >= `NVD_NV_FIRST) && (cmd_addr <= `NVD_NV_LAST);
    assign cmd_idx  = idx_of(cmd_addr);
    assign rd_peek  = cmd_hit ? nv_mem_r[cmd_idx] : 8'h00;
    // host write accepted only when idle
    assign host_wr  = cmd_valid && cmd_write && cmd_hit && !busy_r;
    assign st_fault = !busy_r && !host_wr && fault_pend_r;
    assign st_adc   = !busy_r && !host_wr && !fault_pend_r && adc_pend_r;
    assign commit   = busy_r && (wr_cnt_r == 16'h0000);
    assign load_cfg = ((state_r == st_boot) || (state_r == st_off_wait)) && !busy_r;

// ==========================================
// write engine

    // busy timer
    // busy spans the whole write
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            busy_r   <= 1'b0;
            wr_cnt_r <= 16'h0000;
        end
        else if (host_wr || st_fault || st_adc)
        begin
            busy_r   <= 1'b1;
            wr_cnt_r <= 16'(WR_CYCLES - 1);
        end
        else if (commit)
        begin
            busy_r <= 1'b0;
        end
        else if (busy_r)
        begin
            wr_cnt_r <= wr_cnt_r - 16'h0001;
        end
    end

    // target and data latched at start
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            wr_idx_r  <= 4'h0;
            wr_data_r <= 8'h00;
        end
        else if (host_wr)
        begin
            wr_idx_r  <= cmd_idx;
            wr_data_r <= cmd_wdata;
        end
        else if (st_fault)
        begin
            wr_idx_r  <= IDX_FAULT;
            wr_data_r <= fault_data_r;
        end
        else if (st_adc)
        begin
            wr_idx_r  <= IDX_ADC;
            wr_data_r <= adc_data_r;
        end
    end

    // cells change only at the end of a write
    // cells hold between writes, srst reloads shipped contents
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < NV_N; i++)
            begin
                nv_mem_r[i] <= SHIP[i];
            end
        end
        else if (commit)
        begin
            nv_mem_r[wr_idx_r] <= wr_data_r;
        end
    end

// ==========================================
// log copies

    // fault log copy request, set wins
    // fault log copy
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            fault_pend_r <= 1'b0;
            fault_data_r <= 8'h00;
        end
        else if (fault_rise && log_enable)
        begin
            fault_pend_r <= 1'b1;
            fault_data_r <= fault_log_in;
        end
        else if (st_fault)
        begin
            fault_pend_r <= 1'b0;
        end
    end

    // adc alert log copy request, set wins
    // adc log copy
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            adc_pend_r <= 1'b0;
            adc_data_r <= 8'h00;
        end
        else if (adc_alert_new && log_enable)
        begin
            adc_pend_r <= 1'b1;
            adc_data_r <= adc_log_in;
        end
        else if (st_adc)
        begin
            adc_pend_r <= 1'b0;
        end
    end

// ==========================================
// host answers

    // one answer per command
    // no contents while busy
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            rsp_hit   <= 1'b0;
        end
        else
        begin
            rsp_valid <= cmd_valid;
            rsp_hit   <= cmd_valid && cmd_hit && !busy_r;
            rsp_rdata <= (cmd_valid && !cmd_write && !busy_r) ? rd_peek : 8'h00;
        end
    end

    assign nv_busy = busy_r;

// ==========================================
// boot and reboot

    // sequencer
    // off, reload, wait, restart
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_r   <= st_boot;
            dly_cnt_r <= 32'h0000_0000;
            power_off <= 1'b1;
            boot_done <= 1'b0;
        end
        else
        begin
            boot_done <= 1'b0;
            unique case (state_r)
                st_boot:
                begin
                    if (!busy_r)
                    begin
                        state_r   <= st_idle;
                        power_off <= 1'b0;
                        boot_done <= 1'b1;
                    end
                end
                st_idle:
                begin
                    if (reboot_req)
                    begin
                        state_r   <= st_off_wait;
                        power_off <= 1'b1;
                    end
                end
                st_off_wait:
                begin
                    if (!busy_r)
                    begin
                        state_r   <= st_off_delay;
                        dly_cnt_r <= 32'(REBOOT_CYCLES - 1);
                    end
                end
                st_off_delay:
                begin
                    if (dly_cnt_r == 32'h0000_0000)
                    begin
                        state_r   <= st_idle;
                        power_off <= 1'b0;
                        boot_done <= 1'b1;
                    end
                    else
                    begin
                        dly_cnt_r <= dly_cnt_r - 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    // working defaults loaded from the bank
    // all thirteen config defaults
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cfg_alert_lo          <= `NVD_ALERT_LO_DEF;
            cfg_alert_hi          <= `NVD_ALERT_HI_DEF;
            cfg_fet_timeout       <= `NVD_FET_DEF;
            cfg_io_setup          <= `NVD_IO_DEF;
            cfg_aux_low_limit     <= `NVD_AUX_LO_DEF;
            cfg_aux_high_limit    <= `NVD_AUX_HI_DEF;
            cfg_source_low_limit  <= `NVD_SRC_LO_DEF;
            cfg_source_high_limit <= `NVD_SRC_HI_DEF;
            cfg_sense_low_limit   <= `NVD_SNS_LO_DEF;
            cfg_sense_high_limit  <= `NVD_SNS_HI_DEF;
            cfg_watt_low_limit    <= `NVD_WATT_LO_DEF;
            cfg_watt_high_limit   <= `NVD_WATT_HI_DEF;
            cfg_timebase          <= `NVD_TIMEBASE_DEF;
        end
        else if (load_cfg)
        begin
            cfg_alert_lo          <= nv_mem_r[idx_of(`NVD_ALERT_LO_OFS)];
            cfg_alert_hi          <= nv_mem_r[idx_of(`NVD_ALERT_HI_OFS)];
            cfg_fet_timeout       <= nv_mem_r[idx_of(`NVD_FET_OFS)];
            cfg_io_setup          <= nv_mem_r[idx_of(`NVD_IO_OFS)];
            cfg_aux_low_limit     <= nv_mem_r[idx_of(`NVD_AUX_LO_OFS)];
            cfg_aux_high_limit    <= nv_mem_r[idx_of(`NVD_AUX_HI_OFS)];
            cfg_source_low_limit  <= nv_mem_r[idx_of(`NVD_SRC_LO_OFS)];
            cfg_source_high_limit <= nv_mem_r[idx_of(`NVD_SRC_HI_OFS)];
            cfg_sense_low_limit   <= nv_mem_r[idx_of(`NVD_SNS_LO_OFS)];
            cfg_sense_high_limit  <= nv_mem_r[idx_of(`NVD_SNS_HI_OFS)];
            cfg_watt_low_limit    <= nv_mem_r[idx_of(`NVD_WATT_LO_OFS)];
            cfg_watt_high_limit   <= nv_mem_r[idx_of(`NVD_WATT_HI_OFS)];
            cfg_timebase          <= nv_mem_r[idx_of(`NVD_TIMEBASE_OFS)];
        end
    end

    // fault record restore at load
    // restore when mask default set
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            restore_valid     <= 1'b0;
            restore_fault_log <= 8'h00;
        end
        else
        begin
            restore_valid <= load_cfg && fault_mask_default;
            if (load_cfg)
            begin
                restore_fault_log <= nv_mem_r[IDX_FAULT];
            end
        end
    end

// ==========================================
// checks

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    logic [15:0] hi_len_r;
    nvd_byte_t   peek_r;

    // helper: busy run length and read sample
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            hi_len_r <= 16'h0000;
            peek_r   <= 8'h00;
        end
        else
        begin
            hi_len_r <= busy_r ? hi_len_r + 16'h0001 : 16'h0000;
            peek_r   <= rd_peek;
        end
    end

    sequence s_idle_read;
        cmd_valid && !cmd_write && cmd_hit && !busy_r;
    endsequence

    sequence s_reboot;
        (state_r == st_idle) && reboot_req;
    endsequence

    a_busy_length: assert property (
        $fell(busy_r) |-> (hi_len_r == 16'(WR_CYCLES)))
        else $error("busy run length wrong");

    a_busy_read_blank: assert property (
        (cmd_valid && !cmd_write && busy_r) |=> rsp_valid && !rsp_hit && (rsp_rdata == 8'h00))
        else $error("read during busy not blanked");

    a_read_value: assert property (
        s_idle_read |=> rsp_hit && (rsp_rdata == peek_r))
        else $error("read data not stored value");

    a_host_write: assert property (
        (cmd_valid && cmd_write && cmd_hit && !busy_r) |=> busy_r && (wr_data_r == $past(cmd_wdata)))
        else $error("host write not started");

    a_fault_copy: assert property (
        (fault_rise && log_enable) |=> fault_pend_r && (fault_data_r == $past(fault_log_in)))
        else $error("fault log copy lost");

    a_adc_copy: assert property (
        (adc_alert_new && log_enable) |=> adc_pend_r && (adc_data_r == $past(adc_log_in)))
        else $error("adc log copy lost");

    a_log_gate: assert property (
        (fault_rise && !log_enable && !fault_pend_r) |=> !fault_pend_r)
        else $error("fault copy without enable");

    a_reboot_off: assert property (
        s_reboot |=> power_off ##1 (state_r == st_off_wait) || (state_r == st_off_delay))
        else $error("reboot did not turn off");

    a_restore_mask: assert property (
        restore_valid |-> $past(fault_mask_default) && (restore_fault_log == $past(nv_mem_r[IDX_FAULT])))
        else $error("fault record restore wrong");

    a_ship_values: assert property (
        $past(srst) |-> (cfg_fet_timeout == `NVD_FET_DEF) && (cfg_timebase == `NVD_TIMEBASE_DEF))
        else $error("shipped default wrong");

endmodule : nvd_bank
`default_nettype wire

/* verilog/nvd_map.svh */
`ifndef NVD_MAP_SVH
`define NVD_MAP_SVH
// ==========================================
// nonvolatile byte offsets
`define NVD_NV_FIRST          8'h22
`define NVD_NV_LAST           8'h30
`define NVD_NV_COUNT          15
`define NVD_ALERT_LO_OFS      8'h22
`define NVD_ALERT_HI_OFS      8'h23
`define NVD_FAULT_LOG_OFS     8'h24
`define NVD_ADC_LOG_OFS       8'h25
`define NVD_FET_OFS           8'h26
`define NVD_IO_OFS            8'h27
`define NVD_AUX_LO_OFS        8'h28
`define NVD_AUX_HI_OFS        8'h29
`define NVD_SRC_LO_OFS        8'h2A
`define NVD_SRC_HI_OFS        8'h2B
`define NVD_SNS_LO_OFS        8'h2C
`define NVD_SNS_HI_OFS        8'h2D
`define NVD_WATT_LO_OFS       8'h2E
`define NVD_WATT_HI_OFS       8'h2F
`define NVD_TIMEBASE_OFS      8'h30
// ==========================================
// shipped contents
`define NVD_ALERT_LO_DEF      8'h00
`define NVD_ALERT_HI_DEF      8'h00
`define NVD_FAULT_LOG_DEF     8'h00
`define NVD_ADC_LOG_DEF       8'h00
`define NVD_FET_DEF           8'hFF
`define NVD_IO_DEF            8'h00
`define NVD_AUX_LO_DEF        8'h00
`define NVD_AUX_HI_DEF        8'hFF
`define NVD_SRC_LO_DEF        8'h00
`define NVD_SRC_HI_DEF        8'hFF
`define NVD_SNS_LO_DEF        8'h00
`define NVD_SNS_HI_DEF        8'hFF
`define NVD_WATT_LO_DEF       8'h00
`define NVD_WATT_HI_DEF       8'hFF
`define NVD_TIMEBASE_DEF      8'h08
// ==========================================
// timing
`define NVD_CLK_HZ            64'd10000000
`define NVD_REBOOT_MS         64'd3200
`define NVD_REBOOT_CYC        (`NVD_REBOOT_MS * `NVD_CLK_HZ / 64'd1000)
`define NVD_WR_CYCLES         16
`endif

/* verilog/nvd_pkg.sv */
// ==========================================
// shared types
package nvd_pkg;
    typedef logic [7:0] nvd_byte_t;
    typedef logic [3:0] nvd_idx_t;
    typedef enum logic [1:0] {st_boot, st_idle, st_off_wait, st_off_delay} nvd_state_t;
endpackage : nvd_pkg

/* tb/nvd_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// host side of the register command port
module nvd_host_model
    import nvd_pkg::*;
(
    input  wire logic      ref_clk,   // bank clock
    input  wire logic      rsp_valid, // answer pulse
    input  wire logic      rsp_hit,   // accepted flag
    input  wire nvd_byte_t rsp_rdata, // read data
    input  wire logic      nv_busy,   // write in progress
    output var  logic      cmd_valid, // command strobe
    output var  logic      cmd_write, // write select
    output var  nvd_byte_t cmd_addr,  // byte address
    output var  nvd_byte_t cmd_wdata  // write data
);
    // idle port at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr  = 8'h5A;
        cmd_wdata = 8'hA5;
    end

    // one command: driven on a falling edge, taken on the next rising one
    task automatic xfer(input logic wr, input nvd_byte_t a, input nvd_byte_t d,
                        output logic vld, output logic hit, output nvd_byte_t rd);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr  = a;
        cmd_wdata = d;
        @(negedge ref_clk);
        vld       = rsp_valid;
        hit       = rsp_hit;
        rd        = rsp_rdata;
        cmd_valid = 1'b0;
        cmd_write = ~wr;
        cmd_addr  = ~a;     // released lines show a changed value
        cmd_wdata = ~d;
    endtask : xfer

    task automatic wait_idle;
        for (int k = 0; k < 200 && nv_busy !== 1'b0; k++)
            @(negedge ref_clk);
    endtask : wait_idle
endmodule : nvd_host_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// self-checking bench for the default bank
module testbench
    import nvd_pkg::*;
;
    localparam int        WR = 4;
    localparam int        RB = 20;
    localparam nvd_byte_t SHIP [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
        8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h08};
    logic      ref_clk, srst, log_enable, fault_rise, adc_alert_new;
    logic      fault_mask_default, reboot_req, vld, hit, rv_seen;
    nvd_byte_t fault_log_in, adc_log_in, rd, rv_val;
    wire logic cmd_valid, cmd_write, rsp_valid, rsp_hit, nv_busy;
    wire logic power_off, boot_done, restore_valid;
    wire nvd_byte_t cmd_addr, cmd_wdata, rsp_rdata, restore_fault_log;
    wire nvd_byte_t cfg_w [13];
    int        bad_count, check_count, cyc, busy_len, n;
    int        mem [15];

    // ==========================================
    // clock, timeout and busy length
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (nv_busy === 1'b1)
            busy_len++;
        if (cyc == 20000)
        begin
            bad_count++;
            close_out();
        end
    end

    nvd_bank #(.WR_CYCLES(WR), .REBOOT_CYCLES(RB)) dut_u (
        .ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_hit(rsp_hit), .log_enable(log_enable),
        .fault_rise(fault_rise), .fault_log_in(fault_log_in),
        .adc_alert_new(adc_alert_new), .adc_log_in(adc_log_in),
        .fault_mask_default(fault_mask_default), .reboot_req(reboot_req),
        .nv_busy(nv_busy), .power_off(power_off), .boot_done(boot_done),
        .restore_valid(restore_valid), .restore_fault_log(restore_fault_log),
        .cfg_alert_lo(cfg_w[0]), .cfg_alert_hi(cfg_w[1]), .cfg_fet_timeout(cfg_w[2]),
        .cfg_io_setup(cfg_w[3]), .cfg_aux_low_limit(cfg_w[4]),
        .cfg_aux_high_limit(cfg_w[5]), .cfg_source_low_limit(cfg_w[6]),
        .cfg_source_high_limit(cfg_w[7]), .cfg_sense_low_limit(cfg_w[8]),
        .cfg_sense_high_limit(cfg_w[9]), .cfg_watt_low_limit(cfg_w[10]),
        .cfg_watt_high_limit(cfg_w[11]), .cfg_timebase(cfg_w[12]));

    nvd_host_model host_u (
        .ref_clk(ref_clk), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit),
        .rsp_rdata(rsp_rdata), .nv_busy(nv_busy), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));

    // ==========================================
    // comparisons and accesses
    task automatic chk_byte(string what, nvd_byte_t exp, nvd_byte_t got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task automatic chk_bit(string what, logic exp, logic got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    // one command, answer compared; ok tells whether the bank should take it
    task automatic acc(logic wr, nvd_byte_t a, nvd_byte_t d, logic ok, nvd_byte_t exp);
        host_u.xfer(wr, a, d, vld, hit, rd);
        chk_bit("rsp_valid", 1'b1, vld);
        chk_bit("rsp_hit", ok, hit);
        chk_byte("rsp_rdata", exp, rd);
    endtask : acc

    task automatic cfg_all;
        for (int k = 0; k < 13; k++)
            chk_byte("cfg", nvd_byte_t'(mem[k < 2 ? k : k + 2]), cfg_w[k]);
    endtask : cfg_all

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // ==========================================
    // main sequence
    initial
    begin
        srst               = 1'b1;
        log_enable         = 1'b0;
        fault_rise         = 1'b0;
        adc_alert_new      = 1'b0;
        fault_mask_default = 1'b0;
        reboot_req         = 1'b0;
        fault_log_in       = 8'h00;
        adc_log_in         = 8'h00;
        void'($urandom(32'he6ef9672));
        foreach (mem[i]) mem[i] = SHIP[i];
        repeat (12) @(negedge ref_clk);
        srst = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk_bit("power_off", 1'b0, power_off);
        // shipped contents, config and places outside the bank
        for (int i = 0; i < 15; i++)
            acc(0, nvd_byte_t'(8'h22 + i), 8'h00, 1, SHIP[i]);
        cfg_all();
        acc(0, 8'h31, 8'h00, 0, 8'h00);
        acc(1, 8'h21, 8'h3C, 0, 8'h00);
        $display("test shipped done");
        // random writes, busy length, refused access during busy
        for (int i = 0; i < 15; i++)
        begin
            mem[i]   = $urandom % 256;
            busy_len = 0;
            acc(1, nvd_byte_t'(8'h22 + i), nvd_byte_t'(mem[i]), 1, 8'h00);
            chk_bit("nv_busy", 1'b1, nv_busy);
            acc(0, nvd_byte_t'(8'h22 + i), 8'h00, 0, 8'h00);
            acc(1, nvd_byte_t'(8'h22 + i), ~nvd_byte_t'(mem[i]), 0, 8'h00);
            host_u.wait_idle();
            repeat (2) @(negedge ref_clk);
            chk_byte("busy_len", nvd_byte_t'(WR), nvd_byte_t'(busy_len));
        end
        for (int i = 0; i < 15; i++)
            acc(0, nvd_byte_t'(8'h22 + i), 8'h00, 1, nvd_byte_t'(mem[i]));
        $display("test write done");
        // log copies, fault and alert together, first with logging off, then on
        for (int en = 0; en < 2; en++)
        begin
            @(negedge ref_clk);
            log_enable    = en[0];
            fault_rise    = 1'b1;
            adc_alert_new = 1'b1;
            fault_log_in  = nvd_byte_t'($urandom % 256);
            adc_log_in    = nvd_byte_t'($urandom % 256);
            @(negedge ref_clk);
            fault_rise    = 1'b0;
            adc_alert_new = 1'b0;
            if (en == 1)
            begin
                mem[2] = fault_log_in;
                mem[3] = adc_log_in;
            end
            fault_log_in  = ~fault_log_in;
            adc_log_in    = ~adc_log_in;
            repeat (WR + 3) @(negedge ref_clk);
            host_u.wait_idle();
            repeat (WR + 3) @(negedge ref_clk);
            host_u.wait_idle();
            acc(0, 8'h24, 8'h00, 1, nvd_byte_t'(mem[2]));
            acc(0, 8'h25, 8'h00, 1, nvd_byte_t'(mem[3]));
        end
        $display("test log done");
        // reboot with and without the restore bit
        for (int m = 1; m >= 0; m--)
        begin
            @(negedge ref_clk);
            fault_mask_default = m[0];
            reboot_req         = 1'b1;
            @(negedge ref_clk);
            reboot_req = 1'b0;
            rv_seen    = 1'b0;
            rv_val     = 8'h00;
            n          = 0;
            while (power_off === 1'b1 && n < RB + 10)
            begin
                n++;
                if (restore_valid === 1'b1)
                begin
                    rv_seen = 1'b1;
                    rv_val  = restore_fault_log;
                end
                @(negedge ref_clk);
            end
            chk_byte("off_len", nvd_byte_t'(RB + 1), nvd_byte_t'(n));
            chk_bit("boot_done", 1'b1, boot_done);
            cfg_all();
            chk_bit("restore_valid", m[0], rv_seen);
            if (m == 1)
                chk_byte("restore", nvd_byte_t'(mem[2]), rv_val);
        end
        $display("test reboot done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
